// ---- afrl_map.vh ----
`ifndef AFRL_MAP_VH
`define AFRL_MAP_VH

////////////////////////////////////////////////////////////////////////
// command codes
`define AFRL_CMD_CLEAR     8'h03
`define AFRL_CMD_OT_RESP   8'h50
`define AFRL_CMD_UT_RESP   8'h54
`define AFRL_CMD_VOV_RESP  8'h56
`define AFRL_CMD_VUV_RESP  8'h5a
`define AFRL_CMD_TON_RESP  8'h63
`define AFRL_CMD_ST_BYTE   8'h78
`define AFRL_CMD_ST_WORD   8'h79
`define AFRL_CMD_ST_VOUT   8'h7a
`define AFRL_CMD_ST_VIN    8'h7c
`define AFRL_CMD_ST_TEMP   8'h7d
`define AFRL_CMD_RDLY      8'hdb
`define AFRL_CMD_RCNT      8'hf7

////////////////////////////////////////////////////////////////////////
// reaction byte fields
`define AFRL_ACT_HI        7
`define AFRL_ACT_LO        6
`define AFRL_RTY_HI        5
`define AFRL_RTY_LO        3
`define AFRL_DGL_ZERO      3'h0
`define AFRL_RCNT_INF      3'h7

////////////////////////////////////////////////////////////////////////
// status bit positions
`define AFRL_SB_HIGH       0
`define AFRL_SB_TEMP       2
`define AFRL_SB_VIN_UV     3
`define AFRL_SW_INPUT      5
`define AFRL_SW_VOUT       7
`define AFRL_SV_TON_MAX    2
`define AFRL_SI_VIN_OV     7
`define AFRL_SI_VIN_UV     4
`define AFRL_ST_OT         7
`define AFRL_ST_UT         4

////////////////////////////////////////////////////////////////////////
// reset values
`define AFRL_RESP_RST      8'h00
`define AFRL_RDLY_RST      16'h03e8
`define AFRL_RCNT_RST      3'h0

////////////////////////////////////////////////////////////////////////
// timing
`define AFRL_CLK_NS        10
`define AFRL_TICK_NS       200000
`define AFRL_CLR_S         16
`define AFRL_TICKS_PER_S   5000
`define AFRL_RDLY_MAX      16'hffdc

`endif

// ---- afrl_chan.v ----
`timescale 1ns/1ns
`include "afrl_map.vh"

module afrl_chan #(
	parameter CLR_TICKS = `AFRL_CLR_S * `AFRL_TICKS_PER_S
) (
	// clock and reset
	input  wire        core_clk,
	input  wire        reset,
	input  wire        tick,
	// channel control
	input  wire        on_req,
	input  wire        bias_ok,
	input  wire        seq_off_en,
	input  wire [15:0] toff_ticks,
	input  wire [15:0] retry_ticks,
	input  wire [2:0]  retry_limit,
	// selected fault
	input  wire        flt_shut,
	input  wire [2:0]  flt_id,
	input  wire [2:0]  flt_retry,
	// status
	output wire        chan_en,
	output wire        faulted,
	output wire [2:0]  retry_cnt
);

	localparam S_OFF    = 3'h0;
	localparam S_RUN    = 3'h1;
	localparam S_SEQ    = 3'h2;
	localparam S_DECIDE = 3'h3;
	localparam S_WAIT   = 3'h4;
	localparam S_LATCH  = 3'h5;

	reg [2:0]  st_r;
	reg [15:0] tmr_r;
	reg [2:0]  cnt_r;
	reg [2:0]  lim_r;
	reg [2:0]  rty_r;
	reg [2:0]  id_r;
	reg [31:0] good_r;
	wire       go;
	wire       down;

	assign go        = on_req & bias_ok;
	assign down      = (st_r == S_DECIDE) | (st_r == S_WAIT) |
	                   (st_r == S_LATCH);
	assign chan_en   = (st_r == S_RUN) | (st_r == S_SEQ);
	assign faulted   = down;
	assign retry_cnt = cnt_r;

	////////////////////////////////////////////////////////////////////
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			st_r   <= S_OFF;
			tmr_r  <= 16'h0000;
			cnt_r  <= 3'h0;
			lim_r  <= 3'h0;
			rty_r  <= 3'h0;
			id_r   <= 3'h0;
			good_r <= 32'h0000_0000;
		end else if (!go) begin
			// command off or bias loss ends retry
			st_r <= S_OFF;
		end else begin
			case (st_r)
			S_OFF: begin
				cnt_r <= 3'h0;
				lim_r <= retry_limit;
				id_r  <= 3'h0;
				st_r  <= S_RUN;
			end
			S_RUN: begin
				if (flt_shut) begin
					if (cnt_r != 3'h0 && flt_id != id_r)
						rty_r <= 3'h0;
					else
						rty_r <= flt_retry;
					id_r <= flt_id;
					if (seq_off_en) begin
						tmr_r <= toff_ticks;
						st_r  <= S_SEQ;
					end else begin
						st_r <= S_DECIDE;
					end
				end
			end
			S_SEQ: begin
				if (tick) begin
					if (tmr_r == 16'h0000)
						st_r <= S_DECIDE;
					else
						tmr_r <= tmr_r - 16'h0001;
				end
			end
			S_DECIDE: begin
				if (rty_r != 3'h0 && lim_r != 3'h0 &&
				    (lim_r == `AFRL_RCNT_INF || cnt_r < lim_r)) begin
					tmr_r <= retry_ticks;
					st_r  <= S_WAIT;
				end else begin
					st_r <= S_LATCH;
				end
			end
			S_WAIT: begin
				if (tick) begin
					if (tmr_r == 16'h0000) begin
						if (cnt_r != `AFRL_RCNT_INF)
							cnt_r <= cnt_r + 3'h1;
						st_r <= S_RUN;
					end else begin
						tmr_r <= tmr_r - 16'h0001;
					end
				end
			end
			S_LATCH: begin
				st_r <= S_LATCH;
			end
			default: begin
				st_r <= S_OFF;
			end
			endcase
			if (down) begin
				good_r <= 32'h0000_0000;
			end else if (tick) begin
				if (good_r >= CLR_TICKS - 1) begin
					good_r <= 32'h0000_0000;
					cnt_r  <= 3'h0;
				end else begin
					good_r <= good_r + 32'h0000_0001;
				end
			end
		end
	end

endmodule

// ---- afrl_top.v ----
`timescale 1ns/1ns
`include "afrl_map.vh"

// Notes on behaviour
// - monitor faults set byte, word, class flags
// - every monitor fault pulls alert low
// - action 00b keeps channel running
// - other actions shut or sequence off
// - retry 000b latches channel off
// - retries stop on off, bias loss, different fault
// - retry changes may wait for off-on
// - deglitch field always reads zero
// - turn-on timeout sets vout flags, alert
// - limit zero none, 1-6 exact, 7 unlimited
// - retry interval clamped 13.1 s, 200us steps
// - counter clears after 16 s or off-on
// - clear command wipes flags, keeps faulted-off
module afrl_top #(
	parameter TICK_CYC  = `AFRL_TICK_NS / `AFRL_CLK_NS,
	parameter CLR_TICKS = `AFRL_CLR_S * `AFRL_TICKS_PER_S
) (
	// clock and reset
	input  wire        core_clk,
	input  wire        reset,
	// command port
	input  wire        cmd_wr,
	input  wire        cmd_rd,
	input  wire        cmd_page,
	input  wire [7:0]  cmd_code,
	input  wire [15:0] cmd_wdata,
	output reg  [15:0] rsp_data,
	output reg         rsp_valid,
	// monitor reports
	input  wire [1:0]  ot_evt,
	input  wire [1:0]  ut_evt,
	input  wire        vin_ov_evt,
	input  wire        vin_uv_evt,
	input  wire [1:0]  ton_max_evt,
	// channel control
	input  wire [1:0]  on_req,
	input  wire        bias_ok,
	input  wire [1:0]  seq_off_en,
	input  wire [15:0] turn_off_wait,
	// outputs
	output wire [1:0]  chan_en,
	output wire [1:0]  chan_faulted,
	output wire        host_alert_n
);

	reg [15:0] ot_resp_r;
	reg [15:0] ut_resp_r;
	reg [15:0] ton_resp_r;
	reg [7:0]  vov_resp_r;
	reg [7:0]  vuv_resp_r;
	reg [15:0] rdly_r;
	reg [2:0]  rcnt_r;
	reg [1:0]  st_ot_r;
	reg [1:0]  st_ut_r;
	reg [1:0]  st_ton_r;
	reg        st_vov_r;
	reg        st_vuv_r;
	reg        alert_r;
	reg [31:0] div_r;
	reg [15:0] rd_nxt;
	wire       tick;
	wire       clr;
	wire       any_evt;
	wire [15:0] rdly_clamp;
	wire [7:0] sb;
	wire [7:0] sw_hi;
	wire [7:0] s_vout;
	wire [7:0] s_vin;
	wire [7:0] s_temp;

	function act_on;
		input [7:0] b;
		act_on = |b[`AFRL_ACT_HI:`AFRL_ACT_LO];
	endfunction

	////////////////////////////////////////////////////////////////////
	// 200us tick divider
	assign tick = (div_r == TICK_CYC - 1);

	always @(posedge core_clk or posedge reset) begin
		if (reset)
			div_r <= 32'h0000_0000;
		else if (tick)
			div_r <= 32'h0000_0000;
		else
			div_r <= div_r + 32'h0000_0001;
	end

	////////////////////////////////////////////////////////////////////
	// configuration writes
	assign clr = cmd_wr & (cmd_code == `AFRL_CMD_CLEAR);

	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ot_resp_r  <= {2{`AFRL_RESP_RST}};
			ut_resp_r  <= {2{`AFRL_RESP_RST}};
			ton_resp_r <= {2{`AFRL_RESP_RST}};
			vov_resp_r <= `AFRL_RESP_RST;
			vuv_resp_r <= `AFRL_RESP_RST;
			rdly_r     <= `AFRL_RDLY_RST;
			rcnt_r     <= `AFRL_RCNT_RST;
		end else if (cmd_wr) begin
			case (cmd_code)
			`AFRL_CMD_OT_RESP:
				ot_resp_r[cmd_page*8 +: 8] <=
					{cmd_wdata[7:3], `AFRL_DGL_ZERO};
			`AFRL_CMD_UT_RESP:
				ut_resp_r[cmd_page*8 +: 8] <=
					{cmd_wdata[7:3], `AFRL_DGL_ZERO};
			`AFRL_CMD_TON_RESP:
				ton_resp_r[cmd_page*8 +: 8] <=
					{cmd_wdata[7:3], `AFRL_DGL_ZERO};
			`AFRL_CMD_VOV_RESP:
				vov_resp_r <= {cmd_wdata[7:3], `AFRL_DGL_ZERO};
			`AFRL_CMD_VUV_RESP:
				vuv_resp_r <= {cmd_wdata[7:3], `AFRL_DGL_ZERO};
			`AFRL_CMD_RDLY:
				rdly_r <= cmd_wdata;
			`AFRL_CMD_RCNT:
				rcnt_r <= cmd_wdata[2:0];
			default: begin
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// sticky status and alert
	assign any_evt = (|ot_evt) | (|ut_evt) | vin_ov_evt | vin_uv_evt |
	                 (|ton_max_evt);

	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			st_ot_r  <= 2'h0;
			st_ut_r  <= 2'h0;
			st_ton_r <= 2'h0;
			st_vov_r <= 1'b0;
			st_vuv_r <= 1'b0;
			alert_r  <= 1'b0;
		end else begin
			st_ot_r  <= (clr ? 2'h0 : st_ot_r) | ot_evt;
			st_ut_r  <= (clr ? 2'h0 : st_ut_r) | ut_evt;
			st_ton_r <= (clr ? 2'h0 : st_ton_r) | ton_max_evt;
			st_vov_r <= (~clr & st_vov_r) | vin_ov_evt;
			st_vuv_r <= (~clr & st_vuv_r) | vin_uv_evt;
			alert_r  <= (~clr & alert_r) | any_evt;
		end
	end

	assign host_alert_n = ~alert_r;

	////////////////////////////////////////////////////////////////////
	// status composition for selected page
	assign sb = ({7'h00, st_ot_r[cmd_page] | st_ut_r[cmd_page]}
	            << `AFRL_SB_TEMP) |
	            ({7'h00, st_vuv_r} << `AFRL_SB_VIN_UV) |
	            ({7'h00, st_vov_r | st_ton_r[cmd_page]} << `AFRL_SB_HIGH);
	assign sw_hi = ({7'h00, st_ton_r[cmd_page]} << `AFRL_SW_VOUT) |
	               ({7'h00, st_vov_r | st_vuv_r} << `AFRL_SW_INPUT);
	assign s_vout = {7'h00, st_ton_r[cmd_page]} << `AFRL_SV_TON_MAX;
	assign s_vin  = ({7'h00, st_vov_r} << `AFRL_SI_VIN_OV) |
	                ({7'h00, st_vuv_r} << `AFRL_SI_VIN_UV);
	assign s_temp = ({7'h00, st_ot_r[cmd_page]} << `AFRL_ST_OT) |
	                ({7'h00, st_ut_r[cmd_page]} << `AFRL_ST_UT);

	always @* begin
		rd_nxt = 16'h0000;
		case (cmd_code)
		`AFRL_CMD_OT_RESP:  rd_nxt = {8'h00, ot_resp_r[cmd_page*8 +: 8]};
		`AFRL_CMD_UT_RESP:  rd_nxt = {8'h00, ut_resp_r[cmd_page*8 +: 8]};
		`AFRL_CMD_TON_RESP: rd_nxt = {8'h00, ton_resp_r[cmd_page*8 +: 8]};
		`AFRL_CMD_VOV_RESP: rd_nxt = {8'h00, vov_resp_r};
		`AFRL_CMD_VUV_RESP: rd_nxt = {8'h00, vuv_resp_r};
		`AFRL_CMD_RDLY:     rd_nxt = rdly_r;
		`AFRL_CMD_RCNT:     rd_nxt = {13'h0000, rcnt_r};
		`AFRL_CMD_ST_BYTE:  rd_nxt = {8'h00, sb};
		`AFRL_CMD_ST_WORD:  rd_nxt = {sw_hi, sb};
		`AFRL_CMD_ST_VOUT:  rd_nxt = {8'h00, s_vout};
		`AFRL_CMD_ST_VIN:   rd_nxt = {8'h00, s_vin};
		`AFRL_CMD_ST_TEMP:  rd_nxt = {8'h00, s_temp};
		default:            rd_nxt = 16'h0000;
		endcase
	end

	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rsp_data  <= 16'h0000;
			rsp_valid <= 1'b0;
		end else begin
			rsp_valid <= cmd_rd;
			if (cmd_rd)
				rsp_data <= rd_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// interval clamped, counted in 200us ticks
	assign rdly_clamp = (rdly_r > `AFRL_RDLY_MAX) ? `AFRL_RDLY_MAX : rdly_r;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_ch
			reg  [7:0] sel_b;
			reg  [2:0] sel_id;
			wire [7:0] ot_b;
			wire [7:0] ut_b;
			wire [7:0] tn_b;

			assign ot_b = ot_resp_r[gi*8 +: 8];
			assign ut_b = ut_resp_r[gi*8 +: 8];
			assign tn_b = ton_resp_r[gi*8 +: 8];

			// action 00b never selected to shut down
			always @* begin
				sel_b  = 8'h00;
				sel_id = 3'h0;
				if (ut_evt[gi] && act_on(ut_b)) begin
					sel_b  = ut_b;
					sel_id = 3'h5;
				end
				if (ot_evt[gi] && act_on(ot_b)) begin
					sel_b  = ot_b;
					sel_id = 3'h4;
				end
				if (vin_uv_evt && act_on(vuv_resp_r)) begin
					sel_b  = vuv_resp_r;
					sel_id = 3'h3;
				end
				if (vin_ov_evt && act_on(vov_resp_r)) begin
					sel_b  = vov_resp_r;
					sel_id = 3'h2;
				end
				if (ton_max_evt[gi] && act_on(tn_b)) begin
					sel_b  = tn_b;
					sel_id = 3'h1;
				end
			end

			afrl_chan #(
				.CLR_TICKS (CLR_TICKS)
			) u_chan (
				.core_clk    (core_clk),
				.reset       (reset),
				.tick        (tick),
				.on_req      (on_req[gi]),
				.bias_ok     (bias_ok),
				.seq_off_en  (seq_off_en[gi]),
				.toff_ticks  (turn_off_wait),
				.retry_ticks (rdly_clamp),
				.retry_limit (rcnt_r),
				.flt_shut    (sel_id != 3'h0),
				.flt_id      (sel_id),
				.flt_retry   (sel_b[`AFRL_RTY_HI:`AFRL_RTY_LO]),
				.chan_en     (chan_en[gi]),
				.faulted     (chan_faulted[gi]),
				.retry_cnt   ()
			);
		end
	endgenerate

endmodule

// ---- afrl_checker.sv ----
`timescale 1ns/1ns
module afrl_checker (
	// clock and command port
	input logic        core_clk,
	input logic        reset,
	input logic        cmd_wr,
	input logic        cmd_rd,
	input logic [7:0]  cmd_code,
	input logic [15:0] rsp_data,
	input logic        rsp_valid,
	// monitor and channels
	input logic [1:0]  ot_evt,
	input logic [1:0]  ut_evt,
	input logic        vin_ov_evt,
	input logic        vin_uv_evt,
	input logic [1:0]  ton_max_evt,
	input logic [1:0]  on_req,
	input logic        bias_ok,
	input logic [1:0]  seq_off_en,
	input logic [1:0]  chan_en,
	input logic [1:0]  chan_faulted,
	input logic        host_alert_n
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	wire any_ev = |{ot_evt, ut_evt, vin_ov_evt, vin_uv_evt, ton_max_evt};
	wire ev0 = ot_evt[0] | ut_evt[0] | vin_ov_evt | vin_uv_evt |
		ton_max_evt[0];
	wire clr = cmd_wr && cmd_code == 8'h03;
	wire resp = cmd_code inside {8'h50, 8'h54, 8'h56, 8'h5a, 8'h63};

	alert_on_fault_a: assert property (any_ev |=> !host_alert_n)
		else $error("alert not low after fault");
	alert_release_a: assert property ($rose(host_alert_n) |-> $past(clr))
		else $error("alert released without clear");
	clear_alert_a: assert property (clr && !any_ev |=> host_alert_n)
		else $error("alert not released by clear");
	read_answer_a: assert property (cmd_rd |=> rsp_valid)
		else $error("read answer missing");
	read_idle_a: assert property (!cmd_rd |=> !rsp_valid)
		else $error("read answer without request");
	unmapped_zero_a: assert property (cmd_rd && cmd_code == 8'h00
		|=> rsp_data == 16'h0000)
		else $error("unmapped read not zero");
	deglitch_zero_a: assert property (cmd_rd && resp
		|=> rsp_data[2:0] == 3'h0)
		else $error("deglitch field not zero");
	en_fault_excl_a: assert property ((chan_en & chan_faulted) == 2'b00)
		else $error("channel enabled while faulted");
	bias_loss_a: assert property (!bias_ok [*2] |-> chan_en == 2'b00)
		else $error("channel on without bias");
	turn_on_a: assert property ($rose(chan_en[0])
		|-> $past(on_req[0] && bias_ok))
		else $error("channel on without request");
	fault_stop_a: assert property ($rose(chan_faulted[0])
		&& !seq_off_en[0] |-> $past(ev0))
		else $error("shutdown without fault");
endmodule

// ---- afrl_host.sv ----
`timescale 1ns/1ns
module afrl_host (
	// clock
	input  logic        core_clk,
	// command port
	output logic        cmd_wr,
	output logic        cmd_rd,
	output logic        cmd_page,
	output logic [7:0]  cmd_code,
	output logic [15:0] cmd_wdata,
	input  logic [15:0] rsp_data,
	input  logic        rsp_valid
);
	initial begin
		cmd_wr = 1'b0;
		cmd_rd = 1'b0;
		cmd_page = 1'b0;
		cmd_code = 8'h00;
		cmd_wdata = 16'h0000;
	end
	// one-cycle write strobe, data scrambled once released
	task automatic wr(input logic pg, input logic [7:0] c,
		input logic [15:0] d);
		@(negedge core_clk);
		cmd_wr = 1'b1;
		cmd_page = pg;
		cmd_code = c;
		cmd_wdata = d;
		@(negedge core_clk);
		cmd_wr = 1'b0;
		cmd_wdata = ~d;
	endtask
	// answer taken in the cycle after the read strobe
	task automatic rd(input logic pg, input logic [7:0] c,
		output logic [15:0] d, output logic v);
		@(negedge core_clk);
		cmd_rd = 1'b1;
		cmd_page = pg;
		cmd_code = c;
		@(negedge core_clk);
		cmd_rd = 1'b0;
		cmd_code = ~c;
		d = rsp_data;
		v = rsp_valid;
	endtask
endmodule

// ---- tb.sv ----
`timescale 1ns/1ns
module tb;
	logic        core_clk = 1'b0, reset = 1'b1, bias_ok = 1'b1;
	logic        cmd_wr, cmd_rd, cmd_page, rsp_valid, host_alert_n;
	logic [7:0]  cmd_code, ev = 8'h00;
	logic [15:0] cmd_wdata, rsp_data, tow = 16'h0003;
	logic [1:0]  on_req = 2'b00, seq_off_en = 2'b10, chan_en, chan_faulted;
	int          fails = 0, cmp_count = 0, cyc_n = 0;
	logic [7:0]  rc [5] = '{8'h50, 8'h54, 8'h56, 8'h5a, 8'h63};
	logic [7:0]  em [5] = '{8'h01, 8'h08, 8'h10, 8'h20, 8'h80};
	logic [7:0]  es [5] = '{8'h7d, 8'h7d, 8'h7c, 8'h7c, 8'h7a};
	logic [7:0]  ex [5] = '{8'h80, 8'h10, 8'h80, 8'h10, 8'h04};
	logic [15:0] ew [5] = '{16'h0004, 16'h0004, 16'h2001, 16'h2008, 16'h8001};
	logic [4:0]  ep = 5'b10010;

	always #5 core_clk = ~core_clk;
	afrl_top #(.TICK_CYC(4), .CLR_TICKS(20)) afrl_top_inst (.core_clk, .reset,
		.cmd_wr, .cmd_rd, .cmd_page, .cmd_code, .cmd_wdata, .rsp_data,
		.rsp_valid, .ot_evt(ev[1:0]), .ut_evt(ev[3:2]), .vin_ov_evt(ev[4]),
		.vin_uv_evt(ev[5]), .ton_max_evt(ev[7:6]), .on_req, .bias_ok,
		.seq_off_en, .turn_off_wait(tow), .chan_en, .chan_faulted,
		.host_alert_n);
	afrl_host afrl_host_inst (.core_clk, .cmd_wr, .cmd_rd, .cmd_page,
		.cmd_code, .cmd_wdata, .rsp_data, .rsp_valid);

	////////////////////////////////////////////////////////////////////
	task automatic chk(string n, logic [16:0] got, logic [16:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic rchk(logic pg, logic [7:0] c, logic [15:0] e);
		logic [15:0] d;
		logic        v;
		afrl_host_inst.rd(pg, c, d, v);
		chk($sformatf("read %h", c), {v, d}, {1'b1, e});
	endtask
	task automatic wr(logic pg, logic [7:0] c, logic [15:0] d);
		afrl_host_inst.wr(pg, c, d);
	endtask
	task automatic cyc(int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic pulse(logic [7:0] m);
		@(negedge core_clk);
		ev = m;
		@(negedge core_clk);
		ev = 8'h00;
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	always @(posedge core_clk) begin
		cyc_n++;
		if (cyc_n == 4000) begin
			fails++;
			give_verdict();
		end
	end

	initial begin
		cyc(20);
		reset = 1'b0;
		chk("alert", host_alert_n, 1'b1);
		foreach (rc[i]) begin
			rchk(0, rc[i], 16'h0000);
			wr(1, rc[i], 16'h00ff);
			rchk(1, rc[i], 16'h00f8);
			wr(1, rc[i], 16'h0000);
		end
		rchk(0, 8'hdb, 16'h03e8);
		rchk(0, 8'hf7, 16'h0000);
		rchk(0, 8'h00, 16'h0000);
		wr(0, 8'h78, 16'h00ff);
		rchk(0, 8'h78, 16'h0000);
		wr(0, 8'hdb, 16'hffff);
		rchk(0, 8'hdb, 16'hffff);
		on_req = 2'b11;
		cyc(3);
		for (int k = 0; k < 5; k++) begin
			pulse(em[k]);
			chk("alert", host_alert_n, 1'b0);
			rchk(ep[k], es[k], {8'h00, ex[k]});
			rchk(ep[k], 8'h78, {8'h00, ew[k][7:0]});
			rchk(ep[k], 8'h79, ew[k]);
			chk("enable", chan_en, 2'b11);
			wr(0, 8'h03, 16'h0000);
			chk("alert", host_alert_n, 1'b1);
			rchk(ep[k], 8'h79, 16'h0000);
		end
		wr(0, 8'h50, 16'h00c0);
		pulse(8'h01);
		chk("ch0 off", {chan_en[0], chan_faulted[0]}, 2'b01);
		cyc(5);
		wr(0, 8'h03, 16'h0000);
		chk("ch0 latched", {chan_en[0], chan_faulted[0]}, 2'b01);
		on_req[0] = 1'b0;
		wr(0, 8'h50, 16'h0088);
		wr(0, 8'hf7, 16'h0001);
		wr(0, 8'hdb, 16'h0002);
		on_req[0] = 1'b1;
		cyc(3);
		chk("ch0 on", chan_en[0], 1'b1);
		pulse(8'h01);
		chk("ch0 off", chan_faulted[0], 1'b1);
		repeat (60) if (!chan_en[0]) cyc(1);
		chk("ch0 retry", chan_en[0], 1'b1);
		cyc(100);
		pulse(8'h01);
		repeat (60) if (!chan_en[0]) cyc(1);
		chk("ch0 cleared", chan_en[0], 1'b1);
		wr(0, 8'hf7, 16'h0007);
		pulse(8'h01);
		cyc(60);
		chk("ch0 limit", {chan_en[0], chan_faulted[0]}, 2'b01);
		wr(1, 8'h54, 16'h0040);
		pulse(8'h08);
		cyc(4);
		chk("ch1 seq", chan_en[1], 1'b1);
		cyc(40);
		chk("ch1 off", {chan_en[1], chan_faulted[1]}, 2'b01);
		bias_ok = 1'b0;
		cyc(3);
		chk("bias off", chan_en, 2'b00);
		give_verdict();
	end
endmodule

bind afrl_top afrl_checker afrl_checker_inst (.*);
